/* sdc_host_model.sv */
/* Host adapter model with shadow registers, soft reset and link reset.
 Assumes tasks are called just after a rising clock edge. */
`timescale 1ns/1ps
module sdc_host_model
(
    input wire logic clk_i,
    output logic cmd_wr_o,
    output logic [7:0] cmd_o,
    output logic [7:0] feature_o,
    output logic soft_reset_bit_o,
    output logic oob_start_o,
    output logic [1:0] oob_kind_o
);
    localparam int SOFT_RESET_HOLD_CYC = 1250;
    logic shadow_busy;
    initial
    begin
        {cmd_wr_o, cmd_o, feature_o, soft_reset_bit_o, oob_start_o, oob_kind_o} = '0;
        shadow_busy = 1'b0;
    end
    // Register frame, released bus shows inverted data
    task automatic frame(input logic [7:0] c, input logic [7:0] f, input logic wr, input logic s);
        shadow_busy = 1'b1;
        {cmd_o, feature_o, cmd_wr_o, soft_reset_bit_o} = {c, f, wr, s};
        @(posedge clk_i);
        #1;
        {cmd_o, feature_o, cmd_wr_o, shadow_busy} = {~c, ~f, 2'b00};
    endtask
    task automatic soft_reset();
        frame(8'h00, 8'h00, 1'b0, 1'b1);
        repeat (SOFT_RESET_HOLD_CYC) @(posedge clk_i);
        #1;
        frame(8'h00, 8'h00, 1'b0, 1'b0);
    endtask
    task automatic link_reset(input logic [1:0] k);
        shadow_busy = 1'b1;
        {oob_kind_o, oob_start_o} = {k, 1'b1};
        @(posedge clk_i);
        #1;
        {oob_kind_o, oob_start_o, shadow_busy} = {~k, 2'b00};
    endtask
endmodule

/* sdc_oob_gen.sv */
/*
 Out-of-band burst generator: six bursts of alignment primitives, each
 followed by a gap whose length depends on the signal kind.
 Assumes the caller pulses start only while idle.
*/
`timescale 1ns/1ps
module sdc_oob_gen
    import sdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [1:0] kind_i,
    output logic burst_o,
    output logic busy_o
);
    sdc_oob_state_t state_r, state_nxt;
    logic [OOB_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [2:0] num_r, num_nxt;
    logic long_r, long_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        num_nxt = num_r;
        long_nxt = long_r;
        unique case (state_r)
            SDC_OOB_IDLE:
            begin
                if (start_i)
                begin
                    state_nxt = SDC_OOB_BURST;
                    cnt_nxt = OOB_CNT_W'(OOB_BURST_CYC - 1);
                    num_nxt = 3'h0;
                    long_nxt = (kind_i != SDC_OOB_COMWAKE); // [R5]
                end
            end
            SDC_OOB_BURST:
            begin
                if (cnt_r == '0)
                begin
                    state_nxt = SDC_OOB_GAP;
                    cnt_nxt = long_r ? OOB_CNT_W'(OOB_LONG_GAP_CYC - 1)
                                     : OOB_CNT_W'(OOB_SHORT_GAP_CYC - 1); // [R4]
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            SDC_OOB_GAP:
            begin
                if (cnt_r != '0)
                    cnt_nxt = cnt_r - 1'b1;
                else if (num_r == 3'(OOB_BURSTS - 1))
                    state_nxt = SDC_OOB_IDLE;
                else
                begin
                    state_nxt = SDC_OOB_BURST;
                    cnt_nxt = OOB_CNT_W'(OOB_BURST_CYC - 1); // [R4]
                    num_nxt = num_r + 3'h1;
                end
            end
            default:
                state_nxt = SDC_OOB_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_r <= SDC_OOB_IDLE;
            cnt_r <= '0;
            num_r <= 3'h0;
            long_r <= 1'b0;
            burst_o <= 1'b0;
            busy_o <= 1'b0;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            num_r <= num_nxt;
            long_r <= long_nxt;
            burst_o <= (state_nxt == SDC_OOB_BURST);
            busy_o <= (state_nxt != SDC_OOB_IDLE);
        end
    end
endmodule

/* sdc_pkg.sv */
/*
 Constants for the drive-side control block: out-of-band timing, power-mode
 codes, command codes and state encodings.
 Assumes a 250 MHz core clock.
*/
package sdc_pkg;
    localparam int CLK_PERIOD_PS = 4000;
    // Burst and gap times in picoseconds
    localparam int OOB_BURST_PS = 106700;
    localparam int OOB_LONG_GAP_PS = 320000;
    localparam int OOB_SHORT_GAP_PS = 106700;
    localparam int OOB_BURST_CYC = OOB_BURST_PS / CLK_PERIOD_PS;
    localparam int OOB_LONG_GAP_CYC = OOB_LONG_GAP_PS / CLK_PERIOD_PS;
    localparam int OOB_SHORT_GAP_CYC = OOB_SHORT_GAP_PS / CLK_PERIOD_PS;
    localparam int OOB_BURSTS = 6;
    localparam int OOB_CNT_W = 8;
    localparam logic [7:0] PWR_IDLE_CODE = 8'hFF;
    localparam logic [7:0] PWR_STANDBY_CODE = 8'h00;
    localparam logic [7:0] PWR_FORBIDDEN_CODE = 8'h80;
    localparam logic [7:0] CMD_CHECK_POWER = 8'hE5;
    localparam logic [7:0] CMD_SMART = 8'hB0;
    localparam logic [7:0] SMART_RETURN_STATUS = 8'hDA;
    localparam logic [7:0] SMART_GOOD = 8'h00;
    localparam logic [7:0] SMART_EXCEEDED = 8'h01;
    localparam int NUM_ATTR = 8;
    typedef enum logic [1:0]
    {
        SDC_OOB_IDLE = 2'b00,
        SDC_OOB_BURST = 2'b01,
        SDC_OOB_GAP = 2'b10
    } sdc_oob_state_t;
    typedef enum logic [1:0]
    {
        SDC_OOB_COMRESET = 2'b00,
        SDC_OOB_COMINIT = 2'b01,
        SDC_OOB_COMWAKE = 2'b10
    } sdc_oob_kind_t;
endpackage

/* sdc_top.sv */
/*
 Drive-side host interface control: spin-up strap and activity pin,
 out-of-band signalling, command launch, health status and power mode reply.
 Assumes the host adapter posts register frames as strobes synchronous to clk_i.
*/
`timescale 1ns/1ps
// Summary of operation
// R1: Pin held low by host: spin up immediately, no staggering.
// R2: Pin floating (reads high): staggered spin-up, wait for enable.
// R3: Drive pin low as weak activity indication.
// R4: Out-of-band bursts 106.7 ns, gaps 320 ns or 106.7 ns; the code truncates burst and short gap to 26 cycles (104 ns).
// R5: Long gap for reset and init, short gap for wake.
// R6: Health status ignores advisory attributes, checks only pre-failure ones.
// R7: Power-mode query in idle returns FFh in sector count.
// R8: Power-mode query never returns 80h.
// R9: Host shadow registers carry commands and status.
// R10: Host sets busy and sends frame on command write.
// R11: Host sends frame on control write only if soft reset changes.
// R12: Host sets busy and sends registers on link reset.
// R13: Command starts on command write; other registers already valid.
// R14: Host holds soft reset high at least 5 us.
module sdc_top
    import sdc_pkg::*;
#(
    parameter int N_ATTR = NUM_ATTR
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic spinup_pin_i,
    input wire logic stagger_go_i,
    input wire logic activity_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_i,
    input wire logic [7:0] feature_i,
    input wire logic soft_reset_bit_i,
    input wire logic idle_mode_i,
    input wire logic [N_ATTR-1:0] attr_exceeded_i,
    input wire logic [N_ATTR-1:0] attr_prefail_i,
    input wire logic oob_start_i,
    input wire logic [1:0] oob_kind_i,
    output logic spinup_o,
    output logic act_pin_o,
    output logic act_pin_oe_o,
    output logic cmd_start_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] sector_count_o,
    output logic result_valid_o,
    output logic busy_flag_o,
    output logic oob_burst_o,
    output logic oob_busy_o
);
    logic rst_s1_r, rst_s2_r;
    logic rst_n;
    logic strap_done_r, strap_done_nxt;
    logic immediate_r, immediate_nxt;
    logic spin_nxt;
    logic start_nxt;
    logic [7:0] code_nxt;
    logic [7:0] sc_nxt;
    logic rv_nxt;
    logic busy_nxt;
    logic act_oe_nxt;
    logic burst_nxt;
    logic obusy_nxt;
    logic gen_burst;
    logic gen_busy;
    logic [N_ATTR-1:0] prefail_hit;

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    function automatic logic [7:0] power_code(input logic idle);
        power_code = idle ? PWR_IDLE_CODE : PWR_STANDBY_CODE; // [R7]
        if (power_code == PWR_FORBIDDEN_CODE)
            power_code = PWR_STANDBY_CODE; // [R8]
    endfunction

    genvar g;
    generate
        for (g = 0; g < N_ATTR; g++)
        begin : g_attr
            assign prefail_hit[g] = attr_exceeded_i[g] & attr_prefail_i[g]; // [R6]
        end
    endgenerate

    // Spin-up strap: read once, then immediate or staggered start
    always_comb
    begin
        strap_done_nxt = 1'b1;
        immediate_nxt = strap_done_r ? immediate_r : !spinup_pin_i; // [R1]
        spin_nxt = spinup_o;
        if (strap_done_r && (immediate_r || stagger_go_i)) // [R1] [R2]
            spin_nxt = 1'b1;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_done_r <= 1'b0;
            immediate_r <= 1'b0;
            spinup_o <= 1'b0;
        end
        else if (ce_i)
        begin
            strap_done_r <= strap_done_nxt;
            immediate_r <= immediate_nxt;
            spinup_o <= spin_nxt;
        end
    end

    // Activity indication: pin only ever pulled low, weakly
    always_comb
    begin
        act_oe_nxt = activity_i && strap_done_r; // [R3]
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_pin_o <= 1'b0;
            act_pin_oe_o <= 1'b0;
        end
        else if (ce_i)
        begin
            act_pin_o <= 1'b0;
            act_pin_oe_o <= act_oe_nxt; // [R3]
        end
    end

    // Command launch and result reply
    always_comb
    begin
        start_nxt = 1'b0;
        code_nxt = cmd_code_o;
        sc_nxt = sector_count_o;
        rv_nxt = 1'b0;
        busy_nxt = busy_flag_o;
        if (soft_reset_bit_i)
        begin
            busy_nxt = 1'b1;
        end
        else if (cmd_wr_i)
        begin
            start_nxt = 1'b1; // [R13]
            code_nxt = cmd_i;
            busy_nxt = 1'b0;
            if (cmd_i == CMD_CHECK_POWER)
            begin
                sc_nxt = power_code(idle_mode_i); // [R7] [R8]
                rv_nxt = 1'b1;
            end
            else if (cmd_i == CMD_SMART && feature_i == SMART_RETURN_STATUS)
            begin
                sc_nxt = (|prefail_hit) ? SMART_EXCEEDED : SMART_GOOD; // [R6]
                rv_nxt = 1'b1;
            end
        end
        else
        begin
            busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_start_o <= 1'b0;
            cmd_code_o <= 8'h00;
            sector_count_o <= 8'h00;
            result_valid_o <= 1'b0;
            busy_flag_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cmd_start_o <= start_nxt;
            cmd_code_o <= code_nxt;
            sector_count_o <= sc_nxt;
            result_valid_o <= rv_nxt;
            busy_flag_o <= busy_nxt;
        end
    end

    // Out-of-band status registered once more so outputs leave flops here
    always_comb
    begin
        burst_nxt = gen_burst; // [R4]
        obusy_nxt = gen_busy;
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oob_burst_o <= 1'b0;
            oob_busy_o <= 1'b0;
        end
        else if (ce_i)
        begin
            oob_burst_o <= burst_nxt;
            oob_busy_o <= obusy_nxt;
        end
    end

    sdc_oob_gen u_oob
    (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .start_i(oob_start_i && !gen_busy),
        .kind_i(oob_kind_i),
        .burst_o(gen_burst),
        .busy_o(gen_busy)
    );
endmodule

/* sdc_top_properties.sv */
/* Port checker for the drive-side control block.
 Assumes it is bound to sdc_top and that requests come after reset settles. */
`timescale 1ns/1ps
module sdc_top_properties
    import sdc_pkg::*;
#(
    parameter int N_ATTR = NUM_ATTR
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic cmd_wr_i,
    input wire logic [7:0] cmd_i,
    input wire logic [7:0] feature_i,
    input wire logic soft_reset_bit_i,
    input wire logic idle_mode_i,
    input wire logic [N_ATTR-1:0] attr_exceeded_i,
    input wire logic [N_ATTR-1:0] attr_prefail_i,
    input wire logic [1:0] oob_kind_i,
    input wire logic activity_i,
    input wire logic spinup_o,
    input wire logic act_pin_o,
    input wire logic act_pin_oe_o,
    input wire logic cmd_start_o,
    input wire logic [7:0] cmd_code_o,
    input wire logic [7:0] sector_count_o,
    input wire logic result_valid_o,
    input wire logic busy_flag_o,
    input wire logic oob_burst_o,
    input wire logic oob_busy_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    logic hit;
    logic [7:0] blen_r;
    logic [7:0] glen_r;
    logic [1:0] kind_r;
    assign take = ce_i && cmd_wr_i && !soft_reset_bit_i;
    assign hit = |(attr_exceeded_i & attr_prefail_i);
    // Burst and gap lengths, kind of the running sequence
    always_ff @(posedge clk_i)
    begin
        blen_r <= oob_burst_o ? blen_r + 8'h01 : 8'h00;
        glen_r <= (oob_busy_o && !oob_burst_o) ? glen_r + 8'h01 : 8'h00;
        if ($rose(oob_busy_o))
            kind_r <= $past(oob_kind_i, 2);
    end
    AST_CMD_GO: assert property (take |=> cmd_start_o && cmd_code_o == $past(cmd_i))
        else $error("command start missing");
    AST_PWR_REPLY: assert property (take && cmd_i == CMD_CHECK_POWER |=> result_valid_o
        && sector_count_o == ($past(idle_mode_i) ? 8'hFF : 8'h00))
        else $error("power reply wrong");
    AST_NO_80: assert property (result_valid_o |-> sector_count_o != PWR_FORBIDDEN_CODE)
        else $error("forbidden power reply");
    AST_HEALTH: assert property (take && cmd_i == CMD_SMART && feature_i == SMART_RETURN_STATUS
        |=> result_valid_o && sector_count_o == ($past(hit) ? 8'h01 : 8'h00))
        else $error("health status wrong");
    AST_SOFT_RESET_HOLD: assert property (ce_i && cmd_wr_i && soft_reset_bit_i |=> !cmd_start_o && busy_flag_o)
        else $error("command taken in soft reset");
    AST_BURST_LEN: assert property ($fell(oob_burst_o) |-> blen_r == 8'h1A)
        else $error("burst length wrong");
    AST_GAP_LEN: assert property ($rose(oob_burst_o) && glen_r != 8'h00
        |-> glen_r == (kind_r == 2'h2 ? 8'h1A : 8'h50))
        else $error("gap length wrong");
    AST_SPIN_KEEP: assert property (spinup_o |=> spinup_o)
        else $error("spin-up dropped");
    AST_ACT_PIN: assert property ($changed(act_pin_oe_o) |-> act_pin_oe_o == $past(activity_i) && !act_pin_o)
        else $error("activity pin wrong");
endmodule
bind sdc_top sdc_top_properties #(.N_ATTR(N_ATTR)) i_props (.*);

/* test_sata_drive_host_side_control.sv */
/* Self-checking bench for the drive-side control block.
 Assumes the package, design and host model are compiled first. */
`timescale 1ns/1ps
module test_sata_drive_host_side_control
    import sdc_pkg::*;
;
    logic clk_i, rst_n_i, ce_i, spinup_pin_i, stagger_go_i, activity_i, idle_mode_i;
    logic cmd_wr_i, soft_reset_bit_i, oob_start_i, spinup_o, act_pin_o, act_pin_oe_o;
    logic cmd_start_o, result_valid_o, busy_flag_o, oob_burst_o, oob_busy_o;
    logic [7:0] cmd_i, feature_i, attr_exceeded_i, attr_prefail_i, cmd_code_o, sector_count_o;
    logic [1:0] oob_kind_i;
    int error_cnt = 0;
    int samples_checked = 0;
    sdc_top i_dut (.*);
    sdc_host_model i_host (.clk_i(clk_i), .cmd_wr_o(cmd_wr_i), .cmd_o(cmd_i),
        .feature_o(feature_i), .soft_reset_bit_o(soft_reset_bit_i),
        .oob_start_o(oob_start_i), .oob_kind_o(oob_kind_i));
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic count_while(ref logic s, input logic v, input int lim, output int n);
        n = 0;
        while (s === v && n < lim)
        begin
            n++;
            tick(1);
        end
    endtask
    task automatic run_reset(input logic pin);
        rst_n_i = 1'b0;
        spinup_pin_i = pin;
        tick(8);
        rst_n_i = 1'b1;
        tick(6);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_spin();
        run_reset(1'b0);
        chk({7'h00, spinup_o}, 8'h01);
        activity_i = 1'b1;
        tick(2);
        chk({6'h00, act_pin_o, act_pin_oe_o}, 8'h01);
        activity_i = 1'b0;
        run_reset(1'b1);
        chk({7'h00, spinup_o}, 8'h00);
        stagger_go_i = 1'b1;
        tick(2);
        chk({7'h00, spinup_o}, 8'h01);
        $display("spin-up test done");
    endtask
    task automatic t_cmd();
        for (int i = 0; i < 4; i++)
        begin
            idle_mode_i = i[0];
            attr_exceeded_i = 8'h0F;
            attr_prefail_i = i[0] ? 8'h01 : 8'hF0;
            i_host.frame(i[1] ? CMD_SMART : CMD_CHECK_POWER, SMART_RETURN_STATUS, 1'b1, 1'b0);
            chk({6'h00, cmd_start_o, result_valid_o}, 8'h03);
            chk(sector_count_o, i[1] ? {7'h00, i[0]} : {8{i[0]}});
            chk(cmd_code_o, i[1] ? CMD_SMART : CMD_CHECK_POWER);
            tick(1);
            chk({6'h00, cmd_start_o, result_valid_o}, 8'h00);
        end
        $display("command test done");
    endtask
    task automatic t_soft_reset_bit();
        fork
            i_host.soft_reset();
            begin
                tick(3);
                i_host.frame(CMD_CHECK_POWER, 8'h00, 1'b1, 1'b1);
                chk({6'h00, cmd_start_o, busy_flag_o}, 8'h01);
            end
        join
        tick(2);
        chk({7'h00, busy_flag_o}, 8'h00);
        $display("soft reset test done");
    endtask
    task automatic t_oob();
        int n;
        int g;
        for (int k = 0; k < 3; k++)
        begin
            i_host.link_reset(k[1:0]);
            count_while(oob_burst_o, 1'b0, 9, n);
            count_while(oob_burst_o, 1'b1, 200, n);
            count_while(oob_burst_o, 1'b0, 200, g);
            chk(8'(n), 8'(OOB_BURST_CYC));
            chk(8'(g), k == 2 ? 8'(OOB_SHORT_GAP_CYC) : 8'(OOB_LONG_GAP_CYC));
            count_while(oob_busy_o, 1'b1, 999, n);
            chk({7'h00, oob_busy_o}, 8'h00);
        end
        $display("out-of-band test done");
    endtask
    initial
    begin
        {rst_n_i, spinup_pin_i, stagger_go_i, activity_i, idle_mode_i} = '0;
        {attr_exceeded_i, attr_prefail_i} = '0;
        ce_i = 1'b1;
        t_spin();
        t_cmd();
        t_soft_reset_bit();
        t_oob();
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule
